// File: design/exec_pkg.sv
// Purpose: shared constants and encodings for the flag and load/store execute block
// Assumes: 8-bit data path, 16-bit data-memory addresses, 32 general registers
// Notes: command encodings are fixed codes because the issuing logic drives them
package exec_pkg;

  // widths
  localparam int DATA_W = 8;
  localparam int MEM_ADDR_W = 16;
  localparam int NUM_REGS = 32;
  localparam int REG_IDX_W = 5;
  localparam int DISP_W = 6;
  localparam int BUS_ADDR_W = 6;

  // register bus map
  localparam logic [5:0] REGS_BASE = 6'h00;
  localparam logic [5:0] STATUS_OFFSET = 6'h20;

  // status_flags_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // low byte index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // timing counts in clock cycles
  localparam int FLAG_OP_CYCLES = 1;
  localparam int MEM_OP_CYCLES = 2;

  typedef enum logic [4:0] {
    set_carry_op = 5'h00,
    clear_carry_op = 5'h01,
    set_zero_op = 5'h02,
    clear_zero_op = 5'h03,
    set_negative_op = 5'h04,
    clear_negative_op = 5'h05,
    set_overflow_op = 5'h06,
    clear_overflow_op = 5'h07,
    set_sign_test_op = 5'h08,
    clear_sign_test_op = 5'h09,
    set_half_carry_op = 5'h0a,
    clear_half_carry_op = 5'h0b,
    set_transfer_op = 5'h0c,
    clear_transfer_op = 5'h0d,
    set_int_enable_op = 5'h0e,
    clear_int_enable_op = 5'h0f,
    indirect_load_op = 5'h10,
    offset_load_op = 5'h11,
    direct_load_op = 5'h12,
    indirect_store_op = 5'h13,
    offset_store_op = 5'h14
  } instr_op_e;

  typedef enum logic [1:0] {
    ptr_x = 2'h0,
    ptr_y = 2'h1,
    ptr_z = 2'h2
  } ptr_sel_e;

  typedef enum logic [1:0] {
    mode_plain = 2'h0,
    mode_post_inc = 2'h1,
    mode_pre_dec = 2'h2
  } addr_mode_e;

endpackage

// File: design/ptr_addr_unit.sv
// Purpose: effective address and pointer update for data-memory transfers
// Assumes: purely combinational, evaluated in the accept cycle
// Notes: pointer arithmetic wraps modulo the address width
`timescale 1ns/1ps

module ptr_addr_unit
  import exec_pkg::*;
(
  // pointer and operand
  input wire logic [MEM_ADDR_W-1:0] ptr_val,
  input wire exec_pkg::addr_mode_e mode,
  input wire logic use_disp,
  input wire logic [DISP_W-1:0] disp,
  input wire logic use_direct,
  input wire logic [MEM_ADDR_W-1:0] direct_addr,
  // results
  output logic [MEM_ADDR_W-1:0] eff_addr,
  output logic [MEM_ADDR_W-1:0] ptr_next,
  output logic ptr_we
);

  always_comb begin
    eff_addr = ptr_val;
    ptr_next = ptr_val;
    ptr_we = 1'b0;
    if (use_direct) begin
      eff_addr = direct_addr;
    end else if (use_disp) begin
      // unsigned displacement, pointer left alone
      eff_addr = ptr_val + {{(MEM_ADDR_W-DISP_W){1'b0}}, disp};
    end else begin
      case (mode)
        mode_post_inc: begin
          ptr_next = ptr_val + 16'h0001;
          ptr_we = 1'b1;
        end
        mode_pre_dec: begin
          // access uses the already decremented value
          ptr_next = ptr_val - 16'h0001;
          eff_addr = ptr_val - 16'h0001;
          ptr_we = 1'b1;
        end
        default: begin
          eff_addr = ptr_val;
        end
      endcase
    end
  end

endmodule // ptr_addr_unit

// File: design/flag_ls_exec.sv
// Purpose: executes flag set/clear and data-memory load/store instructions
// Assumes: data memory returns mem_rdata combinationally in the cycle mem_rd is high
// Notes: flag ops finish in one cycle, memory ops hold the block busy for one extra cycle
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module flag_ls_exec
  import exec_pkg::*;
#(
  parameter int DISP_WIDTH = DISP_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // instruction command
  input wire logic instr_valid,
  input wire exec_pkg::instr_op_e instr_op,
  input wire exec_pkg::ptr_sel_e instr_ptr,
  input wire exec_pkg::addr_mode_e instr_mode,
  input wire logic [REG_IDX_W-1:0] instr_reg,
  input wire logic [DISP_W-1:0] instr_disp,
  input wire logic [MEM_ADDR_W-1:0] instr_addr,
  // instruction status
  output logic instr_busy,
  output logic instr_done,
  output logic instr_illegal,
  output logic [DATA_W-1:0] flags_out,
  // data memory
  output logic [MEM_ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic [DATA_W-1:0] mem_rdata,
  // register bus
  input wire logic [BUS_ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata
);

  import exec_pkg::*;

  if (DISP_WIDTH != DISP_W) begin : g_bad_disp
    $error("displacement width must match the command port");
  end

  // the highest pointer pair needs both of its bytes inside the register file
  if (int'(PTR_Z_LO) + 1 >= NUM_REGS) begin : g_bad_ptr
    $error("pointer pairs must fit inside the register file");
  end

  typedef enum logic [0:0] {
    exec_idle,
    exec_mem
  } exec_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  exec_state_e state_q;
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic [DATA_W-1:0] status_q;
  logic busy_q;
  logic done_q;
  logic illegal_q;
  logic load_q;
  logic [REG_IDX_W-1:0] dest_q;
  logic [MEM_ADDR_W-1:0] mem_addr_q;
  logic [DATA_W-1:0] mem_wdata_q;
  logic mem_rd_q;
  logic mem_wr_q;
  logic [DATA_W-1:0] bus_rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic take;
  logic take_mem;
  logic take_flag;
  logic is_flag_op;
  logic is_load;
  logic is_store;
  logic use_disp;
  logic use_direct;
  logic bad_cmd;
  logic flag_val;
  logic [2:0] flag_idx;
  logic [4:0] ptr_lo;
  logic [MEM_ADDR_W-1:0] ptr_val;
  logic [MEM_ADDR_W-1:0] eff_addr;
  logic [MEM_ADDR_W-1:0] ptr_next;
  logic ptr_upd;
  logic ptr_we;
  logic wb_en;

  assign take = clk_en && instr_valid && (state_q == exec_idle);
  // one qualified accept per kind keeps its users from drifting apart
  assign take_mem = take && !bad_cmd && (is_load || is_store);
  assign take_flag = take && !bad_cmd && is_flag_op;

  always_comb begin
    is_flag_op = 1'b0;
    is_load = 1'b0;
    is_store = 1'b0;
    use_disp = 1'b0;
    use_direct = 1'b0;
    flag_idx = 3'h0;
    flag_val = 1'b0;
    case (instr_op)
      set_carry_op, clear_carry_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_C);
      end
      set_zero_op, clear_zero_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_Z);
      end
      set_negative_op, clear_negative_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_N);
      end
      set_overflow_op, clear_overflow_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_V);
      end
      set_sign_test_op, clear_sign_test_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_S);
      end
      set_half_carry_op, clear_half_carry_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_H);
      end
      set_transfer_op, clear_transfer_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_T);
      end
      set_int_enable_op, clear_int_enable_op: begin
        is_flag_op = 1'b1;
        flag_idx = 3'(FLAG_I);
      end
      indirect_load_op: is_load = 1'b1;
      offset_load_op: begin
        is_load = 1'b1;
        use_disp = 1'b1;
      end
      direct_load_op: begin
        is_load = 1'b1;
        use_direct = 1'b1;
      end
      indirect_store_op: is_store = 1'b1;
      offset_store_op: begin
        is_store = 1'b1;
        use_disp = 1'b1;
      end
      default: begin
        is_flag_op = 1'b0;
      end
    endcase
    // even codes set, odd codes clear
    flag_val = ~instr_op[0];
  end

  // x has no displacement form; unknown codes and pointers are refused too
  assign bad_cmd = (!is_flag_op && !is_load && !is_store)
                   || (use_disp && instr_ptr == ptr_x)
                   || ((is_load || is_store) && !use_direct && instr_ptr != ptr_x
                       && instr_ptr != ptr_y && instr_ptr != ptr_z)
                   || ((is_load || is_store) && !use_direct && !use_disp
                       && instr_mode != mode_plain && instr_mode != mode_post_inc
                       && instr_mode != mode_pre_dec);

  always_comb begin
    case (instr_ptr)
      ptr_y: ptr_lo = PTR_Y_LO;
      ptr_z: ptr_lo = PTR_Z_LO;
      default: ptr_lo = PTR_X_LO;
    endcase
  end

  assign ptr_val = {regs_q[ptr_lo + 5'h01], regs_q[ptr_lo]};

  ptr_addr_unit u_ptr_addr (
    .ptr_val(ptr_val),
    .mode(instr_mode),
    .use_disp(use_disp),
    .disp(instr_disp),
    .use_direct(use_direct),
    .direct_addr(instr_addr),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next),
    .ptr_we(ptr_upd)
  );

  // pointer written back at the accept edge, so it is settled before the access ends
  assign ptr_we = take_mem && ptr_upd;
  assign wb_en = clk_en && (state_q == exec_mem) && load_q;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= exec_idle;
      busy_q <= 1'b0;
      load_q <= 1'b0;
      dest_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        exec_idle: begin
          if (take_mem) begin
            // second cycle of a transfer is the memory access itself
            state_q <= exec_mem;
            busy_q <= 1'b1;
            load_q <= is_load;
            dest_q <= instr_reg;
          end
        end
        exec_mem: begin
          state_q <= exec_idle;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= exec_idle;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= take_flag || (state_q == exec_mem);
      illegal_q <= take && bad_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data memory port

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
    end else if (clk_en) begin
      if (take_mem) begin
        mem_addr_q <= eff_addr;
        mem_wdata_q <= regs_q[instr_reg];
        mem_rd_q <= is_load;
        mem_wr_q <= is_store;
      end else begin
        mem_rd_q <= 1'b0;
        mem_wr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // general registers: load write-back, pointer update, then bus write

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_regs
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        regs_q[i] <= REG_RESET;
      end else if (clk_en) begin
        if (wb_en && dest_q == 5'(i)) begin
          regs_q[i] <= mem_rdata;
        end else if (ptr_we && ptr_lo == 5'(i)) begin
          regs_q[i] <= ptr_next[7:0];
        end else if (ptr_we && ptr_lo + 5'h01 == 5'(i)) begin
          regs_q[i] <= ptr_next[15:8];
        end else if (bus_wr && bus_addr == REGS_BASE + 6'(i)) begin
          regs_q[i] <= bus_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags: an instruction beats a bus write in the same cycle

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= STATUS_RESET;
    end else if (clk_en) begin
      if (take_flag) begin
        // only the addressed flag moves
        status_q[flag_idx] <= flag_val;
      end else if (bus_wr && bus_addr == STATUS_OFFSET) begin
        status_q <= bus_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register bus read

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= '0;
    end else if (clk_en) begin
      if (bus_rd && bus_addr < STATUS_OFFSET) begin
        bus_rdata_q <= regs_q[bus_addr[4:0]];
      end else if (bus_rd && bus_addr == STATUS_OFFSET) begin
        bus_rdata_q <= status_q;
      end else begin
        bus_rdata_q <= '0;
      end
    end
  end

  assign instr_busy = busy_q;
  assign instr_done = done_q;
  assign instr_illegal = illegal_q;
  assign flags_out = status_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign bus_rdata = bus_rdata_q;

endmodule // flag_ls_exec

// File: tb/dmem_model.sv
// Purpose: behavioural data memory on the far side of flag_ls_exec
// Assumes: combinational read while mem_rd is high, write on the rising edge
// Notes: outside a read the data lines toggle so that stale data never looks valid
`timescale 1ns/1ps

module dmem_model (
  // clock
  input wire logic sys_clk,
  // access
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_q = 8'h55;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  always @(posedge sys_clk) begin
    idle_q <= ~idle_q;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  assign mem_rdata = mem_rd ? mem[mem_addr] : idle_q;
endmodule // dmem_model

// File: tb/flag_ls_exec_monitor.sv
// Purpose: concurrent checks on the ports of flag_ls_exec
// Assumes: a command is taken when valid, clk_en high and busy low
// Notes: flag op code bits [3:1] equal the flag bit position
`timescale 1ns/1ps

module flag_ls_exec_monitor
  import exec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // command
  input wire logic instr_valid,
  input wire exec_pkg::instr_op_e instr_op,
  input wire exec_pkg::ptr_sel_e instr_ptr,
  input wire exec_pkg::addr_mode_e instr_mode,
  input wire logic [MEM_ADDR_W-1:0] instr_addr,
  // status and memory
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic instr_illegal,
  input wire logic [DATA_W-1:0] flags_out,
  input wire logic [MEM_ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  // register bus
  input wire logic [BUS_ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata
);
  logic acc, fop, offx, mok;
  assign acc = instr_valid && clk_en && !instr_busy;
  assign fop = acc && (instr_op < indirect_load_op);
  assign offx = acc && (instr_op == offset_load_op || instr_op == offset_store_op)
    && instr_ptr == ptr_x;
  assign mok = acc && instr_op >= indirect_load_op && instr_op <= offset_store_op
    && instr_ptr != 2'h3 && instr_mode != 2'h3 && !offx;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_FLAG_SET: assert property (fop && !instr_op[0] |=>
    flags_out[$past(instr_op[3:1])]) else $error("flag not set");
  AST_FLAG_CLR: assert property (fop && instr_op[0] |=>
    !flags_out[$past(instr_op[3:1])]) else $error("flag not cleared");
  AST_FLAG_ONLY: assert property (fop |=>
    ((flags_out ^ $past(flags_out)) & ~(8'h01 << $past(instr_op[3:1]))) == 8'h00)
    else $error("other flag changed");
  AST_FLAG_DONE: assert property (fop |=> instr_done && !instr_busy)
    else $error("flag op not one cycle");
  AST_MEM_SEQ: assert property (mok |=> instr_busy && !instr_done ##1
    instr_done && !instr_busy) else $error("memory op not two cycles");
  AST_MEM_DIR: assert property (mok |=> (mem_rd != mem_wr)
    && (mem_rd == ($past(instr_op) < indirect_store_op))) else $error("wrong strobe");
  AST_DIRECT: assert property (acc && instr_op == direct_load_op |=>
    mem_rd && mem_addr == $past(instr_addr)) else $error("direct address wrong");
  AST_MEM_FLAGS: assert property (mok |=> $stable(flags_out) [*2])
    else $error("flags changed by transfer");
  AST_REFUSE: assert property (offx |=> instr_illegal && !mem_rd && !mem_wr
    && !instr_busy && !instr_done) else $error("offset through first pointer taken");
  AST_RDATA_IDLE: assert property (clk_en && !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_FREEZE: assert property (!clk_en |=> $stable(flags_out) && $stable(instr_done)
    && $stable(instr_busy) && $stable(mem_rd) && $stable(mem_wr))
    else $error("state moved while frozen");
  AST_UNMAPPED: assert property (bus_rd && clk_en && bus_addr > 6'h20 |=>
    bus_rdata == 8'h00) else $error("unmapped read not zero");

  cover property (fop ##1 instr_done);
  cover property (mok && instr_op == indirect_store_op);
  cover property (offx);
  cover property (!clk_en && instr_valid);
endmodule // flag_ls_exec_monitor

bind flag_ls_exec flag_ls_exec_monitor flag_ls_exec_monitor_inst (.sys_clk, .rst, .clk_en,
  .instr_valid, .instr_op, .instr_ptr, .instr_mode, .instr_addr, .instr_busy, .instr_done,
  .instr_illegal, .flags_out, .mem_addr, .mem_rd, .mem_wr, .bus_addr, .bus_rd, .bus_rdata);

// File: tb/tb_top.sv
// Purpose: self-checking bench for flag_ls_exec with a data memory model
// Assumes: inputs change at rising edges, outputs are sampled at falling edges
// Notes: clk_en drops once near the end to show a frozen block takes no command
`timescale 1ns/1ps

module tb_top;
  import exec_pkg::*;
  logic sys_clk = 0, rst = 1, clk_en = 1, instr_valid = 0, bus_wr = 0, bus_rd = 0;
  instr_op_e instr_op = set_carry_op;
  ptr_sel_e instr_ptr = ptr_x;
  addr_mode_e instr_mode = mode_plain;
  logic [4:0] instr_reg = 0, op;
  logic [5:0] instr_disp = 0, bus_addr = 0;
  logic [15:0] instr_addr = 0, mem_addr, v;
  logic [7:0] bus_wdata = 0, mem_rdata, mem_wdata, flags_out, bus_rdata, exp_f, d;
  logic instr_busy, instr_done, instr_illegal, mem_rd, mem_wr;
  int n_fail = 0, tests_run = 0, cyc = 0, n = 0;

  always #20 sys_clk = ~sys_clk;

  flag_ls_exec flag_ls_exec_inst (.sys_clk, .rst, .clk_en, .instr_valid, .instr_op,
    .instr_ptr, .instr_mode, .instr_reg, .instr_disp, .instr_addr, .instr_busy, .instr_done,
    .instr_illegal, .flags_out, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
  dmem_model dmem_model_inst (.sys_clk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);

  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bwr(input logic [5:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= w;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic brd(input logic [5:0] a, output logic [7:0] r);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    r = bus_rdata;
  endtask
  task automatic rdp(input logic [1:0] p, output logic [15:0] r);
    logic [7:0] h, l;
    brd(6'h1b + {3'h0, p, 1'b0}, h);
    brd(6'h1a + {3'h0, p, 1'b0}, l);
    r = {h, l};
  endtask
  // n counts falling edges from accept until done or refusal
  task automatic issue(input logic [4:0] o, input logic [1:0] p, input logic [1:0] md,
      input logic [4:0] r, input logic [5:0] q, input logic [15:0] a);
    @(posedge sys_clk);
    instr_op <= instr_op_e'(o);
    instr_ptr <= ptr_sel_e'(p);
    instr_mode <= addr_mode_e'(md);
    instr_reg <= r;
    instr_disp <= q;
    instr_addr <= a;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(instr_done === 1'b1 || instr_illegal === 1'b1) && n < 4);
  endtask
  task automatic mop(input logic [4:0] o, input logic [1:0] p, input logic [1:0] md,
      input logic [4:0] r, input logic [5:0] q, input logic [15:0] a, ea, np);
    if (o > 5'h12) bwr({1'b0, r}, ea[7:0] ^ 8'hc3);
    issue(o, p, md, r, q, a);
    chk(16'(n), 16'd2, "transfer cycles");
    if (o > 5'h12) begin
      chk(16'(dmem_model_inst.mem[ea]), 16'(ea[7:0] ^ 8'hc3), "stored byte");
    end else begin
      brd({1'b0, r}, d);
      chk(16'(d), 16'(ea[7:0] ^ 8'h5a), "loaded byte");
    end
    rdp(p, v);
    chk(v, np, "pointer after");
    chk(16'(flags_out), 16'(exp_f), "flags after transfer");
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      $display("MISMATCH t=%0t run too long", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    brd(6'h20, d);
    chk(16'(d), 16'(STATUS_RESET), "status after reset");
    bwr(6'h2a, 8'hff);
    brd(6'h2a, d);
    chk(16'(d), 16'h0000, "unmapped read");
    $display("test reset done");
    bwr(6'h20, 8'ha5);
    exp_f = 8'ha5;
    for (int k = 0; k < 16; k++) begin
      op = (k < 8) ? 5'(2 * k) : 5'(2 * (k - 8) + 1);
      issue(op, 0, 0, 0, 0, 0);
      exp_f[op[3:1]] = ~op[0];
      chk(16'(flags_out), 16'(exp_f), "flag op");
      chk(16'(n), 16'd1, "flag op cycles");
    end
    $display("test flags done");
    bwr(6'h1b, 8'h00);
    bwr(6'h1a, 8'h80);
    bwr(6'h1d, 8'h12);
    bwr(6'h1c, 8'hff);
    bwr(6'h1f, 8'h34);
    bwr(6'h1e, 8'h00);
    mop(5'h10, 0, 0, 1, 0, 0, 16'h0080, 16'h0080);
    mop(5'h10, 0, 1, 2, 0, 0, 16'h0080, 16'h0081);
    mop(5'h10, 2, 2, 3, 0, 0, 16'h33ff, 16'h33ff);
    mop(5'h10, 1, 1, 4, 0, 0, 16'h12ff, 16'h1300);
    mop(5'h11, 1, 0, 5, 6'h3f, 0, 16'h133f, 16'h1300);
    mop(5'h11, 2, 0, 6, 6'h05, 0, 16'h3404, 16'h33ff);
    mop(5'h12, 1, 0, 7, 0, 16'hfffe, 16'hfffe, 16'h1300);
    mop(5'h13, 1, 0, 8, 0, 0, 16'h1300, 16'h1300);
    mop(5'h13, 2, 1, 9, 0, 0, 16'h33ff, 16'h3400);
    mop(5'h13, 0, 2, 10, 0, 0, 16'h0080, 16'h0080);
    mop(5'h14, 1, 0, 11, 6'h02, 0, 16'h1302, 16'h1300);
    mop(5'h14, 2, 0, 12, 6'h01, 0, 16'h3401, 16'h3400);
    $display("test transfers done");
    issue(5'h11, 0, 0, 1, 6'h01, 0);
    chk(16'(instr_illegal), 16'h0001, "offset via first pointer refused");
    issue(5'h14, 0, 0, 1, 6'h01, 0);
    chk(16'(instr_illegal), 16'h0001, "offset store via first pointer refused");
    issue(5'h10, 3, 0, 1, 0, 0);
    chk(16'(instr_illegal), 16'h0001, "unknown pointer refused");
    issue(5'h13, 0, 3, 1, 0, 0);
    chk(16'(instr_illegal), 16'h0001, "unknown mode refused");
    issue(5'h15, 0, 0, 1, 0, 0);
    chk(16'(instr_illegal), 16'h0001, "unknown code refused");
    rdp(0, v);
    chk(v, 16'h0080, "pointer kept on refusal");
    $display("test refusal done");
    @(posedge sys_clk);
    clk_en <= 1'b0;
    issue(5'h0a, 0, 0, 0, 0, 0);
    chk(16'(flags_out), 16'(exp_f), "flags held while frozen");
    chk(16'(n), 16'd4, "no completion while frozen");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    issue(5'h0a, 0, 0, 0, 0, 0);
    exp_f[FLAG_H] = 1'b1;
    chk(16'(flags_out), 16'(exp_f), "flag op after freeze");
    $display("test freeze done");
    wrap_up();
  end
endmodule // tb_top
